// ### pin_edge_change_defs.svh
/*
 * Register offsets, field positions and reset values for
 * the pin edge-change interrupt block.
 * Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
 */
`ifndef PIN_EDGE_CHANGE_DEFS_SVH
`define PIN_EDGE_CHANGE_DEFS_SVH

`define OFS_B_RISE      8'h00
`define OFS_B_FALL      8'h04
`define OFS_B_FLAGS     8'h08
`define OFS_C_RISE      8'h0C
`define OFS_C_FALL      8'h10
`define OFS_C_FLAGS     8'h14
`define OFS_E_RISE      8'h18
`define OFS_E_FALL      8'h1C
`define OFS_E_FLAGS     8'h20
`define OFS_CORE_CTRL   8'h24
`define OFS_IRQ_STATUS  8'h28
`define OFS_IRQ_MASK    8'h2C

// Core control: master enable and summary flag bit positions
`define CORE_MASTER_EN_BIT 3
`define CORE_SUMMARY_BIT   0

// Partial port has only this pin implemented
`define PORT_E_PIN      3
`define PORT_E_IMPL     8'h08

`define REG_RESET       8'h00

// Interrupt status bits: one per port
`define IRQ_BIT_B       0
`define IRQ_BIT_C       1
`define IRQ_BIT_E       2

`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ### pin_edge_change_pkg.sv
/*
 * Types shared by the pin edge-change interrupt block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pin_edge_change_pkg;

	typedef logic [7:0]  byte_t;
	typedef logic [31:0] word_t;
	typedef logic [7:0]  addr_t;
	typedef logic [1:0]  resp_t;

	typedef enum logic [2:0] {
		WR_IDLE = 3'h1,
		WR_RESP = 3'h2,
		WR_HOLD = 3'h4
	} wr_state_e;

endpackage

// ### pin_edge_change_interrupt.sv
/*
 * Pin edge-change interrupt logic for two 8-bit ports and one partial
 * port with a single pin, reached over AXI4-Lite.
 * Assumes pin inputs already synchronous to CLK and one CLK at 50 MHz.
 */
// Summary of operation
// RL1: Enabled rising edge sets pin and summary flags
// RL2: Enabled falling edge sets pin and summary flags
// RL3: Disabled polarity never sets flag or interrupts
// RL4: Flags sticky until software writes zero
// RL5: All enables and flags reset to zero
// RL6: Full ports have eight bits, bit n pin n
// RL7: Partial port implements only bit three
// RL8: Partial port other bits read zero, ignore writes
// RL9: Master enable clear: flags set, no interrupt; code gates CHANGE_IRQ and WAKE, IRQ still follows masked status
// RL10: Summary flag is OR of all pin flags
// RL11: Edge during clearing write leaves flag set
// RL12: Enabled edge wakes device when master enabled
// RL13: Edge is sample compared with previous sample
`timescale 1ns/1ns
`include "pin_edge_change_defs.svh"

module pin_edge_change_interrupt
	import pin_edge_change_pkg::*;
(
	input  wire logic                       CLK,      // System clock
	input  wire logic                       RESET,    // Sync reset, high
	input  wire pin_edge_change_pkg::byte_t PORT_B,   // Port B pins
	input  wire pin_edge_change_pkg::byte_t PORT_C,   // Port C pins
	input  wire logic                       PORT_E3,  // Port E pin 3
	input  wire pin_edge_change_pkg::addr_t AWADDR,   // Write address
	input  wire logic                       AWVALID,  // Write addr valid
	output logic                            AWREADY,  // Write addr ready
	input  wire pin_edge_change_pkg::word_t WDATA,    // Write data
	input  wire logic [3:0]                 WSTRB,    // Write strobes
	input  wire logic                       WVALID,   // Write data valid
	output logic                            WREADY,   // Write data ready
	output pin_edge_change_pkg::resp_t      BRESP,    // Write response
	output logic                            BVALID,   // Write resp valid
	input  wire logic                       BREADY,   // Write resp ready
	input  wire pin_edge_change_pkg::addr_t ARADDR,   // Read address
	input  wire logic                       ARVALID,  // Read addr valid
	output logic                            ARREADY,  // Read addr ready
	output pin_edge_change_pkg::word_t      RDATA,    // Read data
	output pin_edge_change_pkg::resp_t      RRESP,    // Read response
	output logic                            RVALID,   // Read data valid
	input  wire logic                       RREADY,   // Read data ready
	output logic                            CHANGE_IRQ, // Gated request
	output logic                            WAKE,     // Wake request
	output logic                            IRQ       // Masked status irq
);
	import pin_edge_change_pkg::*;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	byte_t b_rise_ff, b_fall_ff, b_flag_ff, b_prev_ff;
	byte_t c_rise_ff, c_fall_ff, c_flag_ff, c_prev_ff;
	byte_t e_rise_ff, e_fall_ff, e_flag_ff, e_prev_ff;
	logic  master_en_ff;
	logic [2:0] irq_stat_ff, irq_mask_ff;
	byte_t nxt_b_rise, nxt_b_fall, nxt_b_flag;
	byte_t nxt_c_rise, nxt_c_fall, nxt_c_flag;
	byte_t nxt_e_rise, nxt_e_fall, nxt_e_flag;
	logic  nxt_master_en;
	logic [2:0] nxt_irq_stat;
	logic  chg_irq_ff, wake_ff, irq_ff;

	// ------------------------------------------------------------
	// Bus state
	// ------------------------------------------------------------
	wr_state_e wr_ff, nxt_wr;
	logic  aw_got_ff, w_got_ff, nxt_aw_got, nxt_w_got;
	addr_t awaddr_ff, nxt_awaddr;
	word_t wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	resp_t bresp_ff, nxt_bresp;
	logic  rvalid_ff, nxt_rvalid;
	word_t rdata_ff, nxt_rdata;
	resp_t rresp_ff, nxt_rresp;

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	byte_t e_pins;
	byte_t b_hit, c_hit, e_hit;
	logic  summary;
	assign e_pins = {4'h0, PORT_E3, 3'h0};

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			// Sample versus previous sample; polarity gated by enables
			assign b_hit[gi] = //RL1 RL13 RL6
				(b_rise_ff[gi] & PORT_B[gi] & ~b_prev_ff[gi]) |
				(b_fall_ff[gi] & ~PORT_B[gi] & b_prev_ff[gi]); //RL2 RL3
			assign c_hit[gi] = //RL1 RL6
				(c_rise_ff[gi] & PORT_C[gi] & ~c_prev_ff[gi]) |
				(c_fall_ff[gi] & ~PORT_C[gi] & c_prev_ff[gi]); //RL2 RL3
			assign e_hit[gi] = //RL7
				(e_rise_ff[gi] & e_pins[gi] & ~e_prev_ff[gi]) |
				(e_fall_ff[gi] & ~e_pins[gi] & e_prev_ff[gi]);
		end
	endgenerate

	assign summary = |{b_flag_ff, c_flag_ff, e_flag_ff}; //RL10

	// ------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------
	logic do_write;
	always_comb begin
		nxt_wr     = wr_ff;
		nxt_aw_got = aw_got_ff;
		nxt_w_got  = w_got_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata  = wdata_ff;
		nxt_wstrb  = wstrb_ff;
		nxt_bresp  = bresp_ff;
		do_write   = 1'b0;
		case (wr_ff)
			WR_IDLE: begin
				if (AWVALID && !aw_got_ff) begin
					nxt_aw_got = 1'b1;
					nxt_awaddr = AWADDR;
				end
				if (WVALID && !w_got_ff) begin
					nxt_w_got = 1'b1;
					nxt_wdata = WDATA;
					nxt_wstrb = WSTRB;
				end
				if (aw_got_ff && w_got_ff) begin
					nxt_wr   = WR_HOLD;
				end
			end
			WR_HOLD: begin
				do_write   = 1'b1;
				nxt_aw_got = 1'b0;
				nxt_w_got  = 1'b0;
				nxt_bresp  = (awaddr_ff[1:0] == 2'h0 &&
				              awaddr_ff <= `OFS_IRQ_MASK) ?
				             `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
				nxt_wr     = WR_RESP;
			end
			WR_RESP: begin
				if (BREADY) begin
					nxt_wr = WR_IDLE;
				end
			end
			default: begin
				nxt_wr = WR_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			wr_ff     <= WR_IDLE;
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff  <= 32'h00000000;
			wstrb_ff  <= 4'h0;
			bresp_ff  <= `AXI_RESP_OKAY;
		end else begin
			wr_ff     <= nxt_wr;
			aw_got_ff <= nxt_aw_got;
			w_got_ff  <= nxt_w_got;
			awaddr_ff <= nxt_awaddr;
			wdata_ff  <= nxt_wdata;
			wstrb_ff  <= nxt_wstrb;
			bresp_ff  <= nxt_bresp;
		end
	end

	assign AWREADY = (wr_ff == WR_IDLE) && !aw_got_ff;
	assign WREADY  = (wr_ff == WR_IDLE) && !w_got_ff;
	assign BVALID  = (wr_ff == WR_RESP);
	assign BRESP   = bresp_ff;

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	logic  rd_take, stat_read;
	word_t rd_word;
	always_comb begin
		rd_take   = ARVALID && !rvalid_ff;
		stat_read = 1'b0;
		rd_word   = 32'h00000000;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		nxt_rvalid = rvalid_ff;
		case (ARADDR)
			`OFS_B_RISE:     rd_word[7:0] = b_rise_ff;
			`OFS_B_FALL:     rd_word[7:0] = b_fall_ff;
			`OFS_B_FLAGS:    rd_word[7:0] = b_flag_ff;
			`OFS_C_RISE:     rd_word[7:0] = c_rise_ff;
			`OFS_C_FALL:     rd_word[7:0] = c_fall_ff;
			`OFS_C_FLAGS:    rd_word[7:0] = c_flag_ff;
			`OFS_E_RISE:     rd_word[7:0] = e_rise_ff; //RL8
			`OFS_E_FALL:     rd_word[7:0] = e_fall_ff;
			`OFS_E_FLAGS:    rd_word[7:0] = e_flag_ff;
			`OFS_CORE_CTRL: begin
				rd_word[`CORE_MASTER_EN_BIT] = master_en_ff;
				rd_word[`CORE_SUMMARY_BIT]   = summary;
			end
			`OFS_IRQ_STATUS: begin
				rd_word[2:0] = irq_stat_ff;
				stat_read    = rd_take;
			end
			`OFS_IRQ_MASK:   rd_word[2:0] = irq_mask_ff;
			default:         rd_word = 32'h00000000;
		endcase
		if (rd_take) begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = rd_word;
			nxt_rresp  = (ARADDR[1:0] == 2'h0 && ARADDR <= `OFS_IRQ_MASK) ?
			             `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (rvalid_ff && RREADY) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= `AXI_RESP_OKAY;
		end else begin
			rvalid_ff <= nxt_rvalid;
			rdata_ff  <= nxt_rdata;
			rresp_ff  <= nxt_rresp;
		end
	end

	assign ARREADY = !rvalid_ff;
	assign RVALID  = rvalid_ff;
	assign RDATA   = rdata_ff;
	assign RRESP   = rresp_ff;

	// ------------------------------------------------------------
	// Register update
	// ------------------------------------------------------------
	// Byte lane 0 carries every register; other lanes are ignored.
	function automatic byte_t upd(input byte_t cur, input byte_t msk,
	                              input logic hit);
		upd = hit ? (wdata_ff[7:0] & msk) : cur;
	endfunction

	logic wr0;
	always_comb begin
		wr0 = do_write && wstrb_ff[0];
		nxt_b_rise = upd(b_rise_ff, 8'hFF, wr0 && awaddr_ff == `OFS_B_RISE);
		nxt_b_fall = upd(b_fall_ff, 8'hFF, wr0 && awaddr_ff == `OFS_B_FALL);
		nxt_c_rise = upd(c_rise_ff, 8'hFF, wr0 && awaddr_ff == `OFS_C_RISE);
		nxt_c_fall = upd(c_fall_ff, 8'hFF, wr0 && awaddr_ff == `OFS_C_FALL);
		nxt_e_rise = upd(e_rise_ff, `PORT_E_IMPL,
		                 wr0 && awaddr_ff == `OFS_E_RISE); //RL7 RL8
		nxt_e_fall = upd(e_fall_ff, `PORT_E_IMPL,
		                 wr0 && awaddr_ff == `OFS_E_FALL); //RL8
		// Software may only clear flags; hardware set wins the same cycle
		nxt_b_flag = upd(b_flag_ff, b_flag_ff,
		                 wr0 && awaddr_ff == `OFS_B_FLAGS) | b_hit; //RL4 RL11
		nxt_c_flag = upd(c_flag_ff, c_flag_ff,
		                 wr0 && awaddr_ff == `OFS_C_FLAGS) | c_hit; //RL4 RL11
		nxt_e_flag = (upd(e_flag_ff, e_flag_ff,
		                 wr0 && awaddr_ff == `OFS_E_FLAGS) | e_hit)
		             & `PORT_E_IMPL; //RL8 RL11
		nxt_master_en = (wr0 && awaddr_ff == `OFS_CORE_CTRL) ?
		                wdata_ff[`CORE_MASTER_EN_BIT] : master_en_ff;
		// Sticky per-port events, cleared by a status read; set wins
		nxt_irq_stat = (stat_read ? 3'h0 : irq_stat_ff) |
		               {|e_hit, |c_hit, |b_hit};
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			b_rise_ff    <= `REG_RESET; //RL5
			b_fall_ff    <= `REG_RESET;
			b_flag_ff    <= `REG_RESET;
			c_rise_ff    <= `REG_RESET;
			c_fall_ff    <= `REG_RESET;
			c_flag_ff    <= `REG_RESET;
			e_rise_ff    <= `REG_RESET;
			e_fall_ff    <= `REG_RESET;
			e_flag_ff    <= `REG_RESET;
			b_prev_ff    <= 8'h00;
			c_prev_ff    <= 8'h00;
			e_prev_ff    <= 8'h00;
			master_en_ff <= 1'b0;
			irq_stat_ff  <= 3'h0;
			irq_mask_ff  <= 3'h0;
			chg_irq_ff   <= 1'b0;
			wake_ff      <= 1'b0;
			irq_ff       <= 1'b0;
		end else begin
			b_rise_ff    <= nxt_b_rise;
			b_fall_ff    <= nxt_b_fall;
			b_flag_ff    <= nxt_b_flag;
			c_rise_ff    <= nxt_c_rise;
			c_fall_ff    <= nxt_c_fall;
			c_flag_ff    <= nxt_c_flag;
			e_rise_ff    <= nxt_e_rise;
			e_fall_ff    <= nxt_e_fall;
			e_flag_ff    <= nxt_e_flag;
			b_prev_ff    <= PORT_B; //RL13
			c_prev_ff    <= PORT_C;
			e_prev_ff    <= e_pins;
			master_en_ff <= nxt_master_en;
			irq_stat_ff  <= nxt_irq_stat;
			if (wr0 && awaddr_ff == `OFS_IRQ_MASK) begin
				irq_mask_ff <= wdata_ff[2:0];
			end
			// Flags keep setting with master off; only the change request and wake are gated
			chg_irq_ff   <= nxt_master_en & |{nxt_b_flag, nxt_c_flag,
			                                  nxt_e_flag}; //RL9 RL10
			// Wake follows a fresh edge so flags are already updated
			wake_ff      <= master_en_ff & |{b_hit, c_hit, e_hit}; //RL12
			irq_ff       <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

	assign CHANGE_IRQ = chg_irq_ff;
	assign WAKE       = wake_ff;
	assign IRQ        = irq_ff;

endmodule

// ### pin_edge_change_pins.sv
/*
 * Pin-side model: drives the levels on the three ports' pins.
 * Assumes the bench calls drive() just after a rising clock edge.
 */
`timescale 1ns/1ns

module pin_edge_change_pins
	import pin_edge_change_pkg::*;
(
	output pin_edge_change_pkg::byte_t pin_b, // Port B levels
	output pin_edge_change_pkg::byte_t pin_c, // Port C levels
	output logic                       pin_e3 // Port E pin 3 level
);
	initial begin
		pin_b = 8'h00;
		pin_c = 8'h00;
		pin_e3 = 1'b0;
	end

	// Push-pull levels only: the pins never float, so no release to model
	task automatic drive(input byte_t b, input byte_t c, input logic e);
		pin_b <= b;
		pin_c <= c;
		pin_e3 <= e;
	endtask
endmodule

// ### pin_edge_change_assertions.sv
/*
 * Concurrent checks on the ports of the pin edge-change block.
 * Assumes one clock domain and the top module's port names.
 */
`timescale 1ns/1ns
`include "pin_edge_change_defs.svh"

module pin_edge_change_assertions
	import pin_edge_change_pkg::*;
(
	input wire logic CLK, RESET, AWVALID, AWREADY, WVALID, WREADY,
	input wire logic BVALID, ARVALID, ARREADY, RVALID,
	input wire logic PORT_E3, CHANGE_IRQ, WAKE, IRQ,
	input wire pin_edge_change_pkg::byte_t PORT_B, PORT_C,
	input wire pin_edge_change_pkg::addr_t ARADDR,
	input wire pin_edge_change_pkg::word_t RDATA
);
	logic [3:0] since_wr_ff;
	logic [3:0] nxt_since_wr;

	// Cycles since the last write address was taken, saturating
	always_comb begin
		nxt_since_wr = since_wr_ff;
		if (AWVALID && AWREADY)
			nxt_since_wr = 4'h0;
		else if (since_wr_ff != 4'hF)
			nxt_since_wr = since_wr_ff + 4'h1;
	end
	always_ff @(posedge CLK) begin
		since_wr_ff <= RESET ? 4'hF : nxt_since_wr;
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence wr_taken;
		AWVALID && AWREADY && WVALID && WREADY;
	endsequence
	sequence rd_taken;
		ARVALID && ARREADY;
	endsequence
	sequence rd_partial;
		ARVALID && ARREADY &&
		ARADDR inside {`OFS_E_RISE, `OFS_E_FALL, `OFS_E_FLAGS};
	endsequence
	sequence pin_moved;
		$past(PORT_B) != $past(PORT_B, 2) ||
		$past(PORT_C) != $past(PORT_C, 2) ||
		$past(PORT_E3) != $past(PORT_E3, 2);
	endsequence

	chk_reset_quiet: assert property (disable iff (1'b0)
		RESET |=> !CHANGE_IRQ && !WAKE && !IRQ && !BVALID && !RVALID)
		else $error("outputs active after reset");
	chk_wake_edge: assert property (WAKE |-> pin_moved)
		else $error("wake with no pin edge");
	chk_wake_request: assert property (WAKE |-> ##[0:1] CHANGE_IRQ)
		else $error("wake with no change request");
	chk_sticky_irq: assert property (
		$fell(CHANGE_IRQ) |-> since_wr_ff <= 4'h4)
		else $error("change request dropped without a write");
	// Both halves taken at one edge: pending, then hold, then response
	chk_write_answer: assert property (wr_taken |-> ##3 BVALID)
		else $error("write response missing");
	chk_read_answer: assert property (rd_taken |=> RVALID)
		else $error("read data not one cycle after address");
	chk_partial_zero: assert property (
		rd_partial |=> (RDATA & ~{24'h0, `PORT_E_IMPL}) == 32'h0)
		else $error("unimplemented partial port bit read as one");
	chk_upper_zero: assert property (RVALID |-> RDATA[31:8] == 24'h0)
		else $error("read data above the register width");
endmodule

bind pin_edge_change_interrupt pin_edge_change_assertions i_chk (.*);

// ### pin_edge_change_interrupt_tb.sv
/*
 * Self-checking bench for the pin edge-change block over AXI4-Lite.
 * Assumes the design, the pin model and the checker compile before it.
 */
`timescale 1ns/1ns
`include "pin_edge_change_defs.svh"

module pin_edge_change_interrupt_tb;
	import pin_edge_change_pkg::*;

	logic  CLK, RESET, PORT_E3, AWVALID, AWREADY, WVALID, WREADY, BVALID;
	logic  BREADY, ARVALID, ARREADY, RVALID, RREADY, CHANGE_IRQ, WAKE, IRQ;
	logic  [3:0] WSTRB;
	byte_t PORT_B, PORT_C;
	addr_t AWADDR, ARADDR;
	word_t WDATA, RDATA, rd_v;
	resp_t BRESP, RRESP, rs;
	int    n_fail = 0;
	int    checks_done = 0;

	pin_edge_change_interrupt i_pin_edge_change_interrupt (.*);
	pin_edge_change_pins i_pin_edge_change_pins (
		.pin_b (PORT_B),
		.pin_c (PORT_C),
		.pin_e3(PORT_E3)
	);

	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string what, input word_t exp, input word_t got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic hang;
		n_fail++;
		$display("CHECK FAILED handshake exp answer got none");
		wrap_up();
	endtask

	// Each valid drops after the first edge that finds its ready high, so no half is ever taken twice
	task automatic wr(input addr_t a, input word_t d);
		int i;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		i = 0;
		do begin
			@(posedge CLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
			i++;
		end while (!BVALID && i < 20);
		if (!BVALID) hang();
		rs = BRESP;
	endtask

	task automatic rd(input addr_t a);
		int i;
		ARADDR <= a;
		ARVALID <= 1'b1;
		i = 0;
		do begin
			@(posedge CLK);
			if (ARREADY) ARVALID <= 1'b0;
			i++;
		end while (!RVALID && i < 20);
		if (!RVALID) hang();
		rd_v = RDATA;
		rs = RRESP;
	endtask

	task automatic rck(input addr_t a, input word_t exp, input string what);
		rd(a);
		chk(what, exp, rd_v);
	endtask

	// Wake is a one-cycle pulse: look at it in the cycle it stands
	task automatic pins(input byte_t b, input byte_t c, input logic e,
	                    input logic wk);
		i_pin_edge_change_pins.drive(b, c, e);
		repeat (2) @(posedge CLK);
		chk("wake pulse", word_t'(wk), word_t'(WAKE));
		@(posedge CLK);
		chk("wake ended", 32'h0, word_t'(WAKE));
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		RESET = 1'b1;
		{AWVALID, WVALID, ARVALID} = 3'h0;
		{BREADY, RREADY} = 2'h3;
		WSTRB = 4'hF;
		AWADDR = 8'h00;
		ARADDR = 8'h00;
		WDATA = 32'h0;
		repeat (4) @(posedge CLK);
		RESET <= 1'b0;
		for (int a = 0; a <= 'h2C; a += 4)
			rck(8'(a), 32'h0, "reset value");
		wr(`OFS_E_RISE, 32'hFFFF_FFFF);
		rck(`OFS_E_RISE, 32'h08, "partial rise enable");
		wr(`OFS_B_RISE, 32'hFF);
		chk("write resp", word_t'(`AXI_RESP_OKAY), word_t'(rs));
		rck(`OFS_B_RISE, 32'hFF, "rise enable");
		chk("read resp", word_t'(`AXI_RESP_OKAY), word_t'(rs));
		wr(`OFS_C_FALL, 32'hFF);
		wr(`OFS_E_FALL, 32'h08);
		wr(`OFS_IRQ_MASK, 32'h07);
		wr(`OFS_CORE_CTRL, 32'h08);
		// Port C rises with only its fall enables set
		pins(8'h5A, 8'hFF, 1'b0, 1'b1);
		chk("change request", 32'h1, word_t'(CHANGE_IRQ));
		chk("irq", 32'h1, word_t'(IRQ));
		rck(`OFS_B_FLAGS, 32'h5A, "rise flags");
		rck(`OFS_C_FLAGS, 32'h00, "disabled rise");
		rck(`OFS_CORE_CTRL, 32'h09, "summary set");
		rck(`OFS_IRQ_STATUS, 32'h01, "irq status");
		rck(`OFS_IRQ_STATUS, 32'h00, "status after read");
		repeat (2) @(posedge CLK);
		chk("irq after read", 32'h0, word_t'(IRQ));
		wr(`OFS_B_FLAGS, 32'hF5);
		rck(`OFS_B_FLAGS, 32'h50, "partly cleared");
		wr(`OFS_B_FLAGS, 32'h00);
		rck(`OFS_B_FLAGS, 32'h00, "cleared");
		pins(8'h00, 8'h0F, 1'b1, 1'b1);
		rck(`OFS_B_FLAGS, 32'h00, "disabled fall");
		rck(`OFS_C_FLAGS, 32'hF0, "fall flags");
		rck(`OFS_E_FLAGS, 32'h08, "partial flag");
		rck(`OFS_IRQ_STATUS, 32'h06, "irq status two ports");
		wr(`OFS_IRQ_MASK, 32'h00);
		pins(8'h00, 8'h0F, 1'b0, 1'b1);
		chk("masked irq", 32'h0, word_t'(IRQ));
		wr(`OFS_IRQ_MASK, 32'h04);
		repeat (2) @(posedge CLK);
		chk("unmasked irq", 32'h1, word_t'(IRQ));
		rck(`OFS_IRQ_STATUS, 32'h04, "irq status partial");
		// Master enable off: flags still set, no request
		wr(`OFS_CORE_CTRL, 32'h00);
		wr(`OFS_C_FLAGS, 32'h00);
		wr(`OFS_E_FLAGS, 32'h00);
		pins(8'h01, 8'h0F, 1'b0, 1'b0);
		chk("request gated", 32'h0, word_t'(CHANGE_IRQ));
		rck(`OFS_CORE_CTRL, 32'h01, "summary gated");
		// A new edge lands on the same edge as the clearing write
		fork
			wr(`OFS_B_FLAGS, 32'h00);
			begin
				repeat (2) @(posedge CLK);
				i_pin_edge_change_pins.drive(8'h03, 8'h0F, 1'b0);
			end
		join
		rck(`OFS_B_FLAGS, 32'h02, "edge during clear");
		rd(8'h30);
		chk("unmapped read", word_t'(`AXI_RESP_SLVERR), word_t'(rs));
		wr(8'h31, 32'h1);
		chk("unaligned write", word_t'(`AXI_RESP_SLVERR), word_t'(rs));
		RESET <= 1'b1;
		repeat (4) @(posedge CLK);
		RESET <= 1'b0;
		rck(`OFS_B_RISE, 32'h00, "second reset");
		rck(`OFS_B_FLAGS, 32'h00, "second reset flags");
		wrap_up();
	end
endmodule
